// ---- rtl/rsl_reset_source.sv ----
// Operation
// - enable flag makes comparator a reset source
// - noninverting below inverting input causes reset
// - comparator flag reads one only after comparator
// - internal resets never drive external pin
// - watchdog expiry resets and sets bit three
// - enabled data-move write above limit resets
// - code-move read above limit resets
// - branch fetch above limit resets
// - security-forbidden flash access resets
// - flash error reset sets bit six
// - software flag write forces reset, reads one
// - store-write enable steers data-move writes to flash
`timescale 1ns/1ps
`include "rsl_defines.svh"

module rsl_reset_source
   import rsl_pkg::*;
#(
   parameter int HOLD_CYCLES = `RSL_HOLD_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic comparator_out,
   input wire logic comparator_reset_enable_flag,
   input wire logic watchdog_expired,
   input wire logic software_reset_write,
   input wire logic [15:0] access_addr,
   input wire logic data_move_write,
   input wire logic code_move_read,
   input wire logic branch_fetch,
   input wire logic program_store_write_enable,
   input wire logic security_violation,
   output logic flash_write_redirect,
   output logic system_reset,
   output logic [7:0] reset_source_register,
   output logic ext_reset_pin_oe
);
   // all sequencer state in one word, so reset and next value cannot drift apart
   typedef struct packed {
      rsl_state_t state;
      logic [`RSL_CNT_WIDTH-1:0] count;
      logic [`RSL_SRC_WIDTH-1:0] source;
      logic reset_out;
      logic redirect;
   } rsl_regs_t;

   rsl_regs_t state_reg;
   rsl_regs_t state_next;
   logic flash_error;
   logic comp_fire;
   rsl_cause_t cause;

   // range and lock checks stay combinational so the cause is taken in its own cycle
   rsl_flash_check u_flash_check (
      .access_addr(access_addr),
      .data_move_write(data_move_write),
      .code_move_read(code_move_read),
      .branch_fetch(branch_fetch),
      .program_store_write_enable(program_store_write_enable),
      .security_violation(security_violation),
      .flash_error(flash_error)
   );

   // comparator output low means noninverting input is below inverting
   assign comp_fire = comparator_reset_enable_flag && !comparator_out;

   // priority when causes collide: comparator, watchdog, flash, software
   always_comb begin
      if (comp_fire) begin
         cause = RSL_CAUSE_COMP;
      end else if (watchdog_expired) begin
         cause = RSL_CAUSE_WDOG;
      end else if (flash_error) begin
         cause = RSL_CAUSE_FLASH;
      end else if (software_reset_write) begin
         cause = RSL_CAUSE_SOFT;
      end else begin
         cause = RSL_CAUSE_NONE;
      end
   end

   // sequencer: causes are ignored during hold so the first cause stays recorded
   always_comb begin
      state_next = state_reg;
      state_next.redirect = program_store_write_enable && data_move_write;
      case (state_reg.state)
         RSL_RUN: begin
            if (cause != RSL_CAUSE_NONE) begin
               state_next.state = RSL_HOLD;
               state_next.count = `RSL_CNT_WIDTH'(HOLD_CYCLES - 1);
               state_next.reset_out = 1'b1;
               state_next.source = '0;
               state_next.source[`RSL_BIT_COMPARATOR] = (cause == RSL_CAUSE_COMP);
               state_next.source[`RSL_BIT_WATCHDOG] = (cause == RSL_CAUSE_WDOG);
               state_next.source[`RSL_BIT_FLASH_ERROR] = (cause == RSL_CAUSE_FLASH);
               state_next.source[`RSL_BIT_SOFTWARE] = (cause == RSL_CAUSE_SOFT);
            end
         end
         RSL_HOLD: begin
            if (state_reg.count == '0) begin
               state_next.state = RSL_RUN;
               state_next.reset_out = 1'b0;
            end else begin
               state_next.count = state_reg.count - 1'b1;
            end
         end
         default: begin
            state_next.state = RSL_RUN;
            state_next.reset_out = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '{state: RSL_RUN, count: '0, source: '0, reset_out: 1'b0,
                        redirect: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign system_reset = state_reg.reset_out;
   assign reset_source_register = state_reg.source;
   assign flash_write_redirect = state_reg.redirect;
   // internal causes never drive the external reset pin
   assign ext_reset_pin_oe = 1'b0;

   sequence s_cause_seen;
      state_reg.state == RSL_RUN && cause != RSL_CAUSE_NONE;
   endsequence

   // reset is seen high one edge after the cause and low again hold cycles later
   sequence s_hold_then_release;
      system_reset [*1] ##(HOLD_CYCLES) !system_reset;
   endsequence

   // while the hold runs, any new cause must leave no trace
   sequence s_hold_active;
      state_reg.state == RSL_HOLD;
   endsequence

   a_comp_reset_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && comp_fire) |=> system_reset
         && reset_source_register[`RSL_BIT_COMPARATOR])
      else $error("comparator cause not recorded");
   a_comp_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && !comparator_reset_enable_flag && !watchdog_expired
         && !flash_error && !software_reset_write) |=> !system_reset)
      else $error("reset without cause");
   a_comp_flag_only: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && cause != RSL_CAUSE_NONE && !comp_fire)
         |=> !reset_source_register[`RSL_BIT_COMPARATOR])
      else $error("comparator flag set for other cause");
   a_pin_untouched: assert property (@(posedge core_clk) disable iff (!rstn)
      system_reset |-> !ext_reset_pin_oe)
      else $error("reset pin driven");
   a_wdog_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && watchdog_expired && !comp_fire)
         |=> reset_source_register[`RSL_BIT_WATCHDOG] && system_reset)
      else $error("watchdog flag missing");
   a_flash_write: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && data_move_write && program_store_write_enable
         && access_addr > `RSL_USER_CODE_LIMIT) |=> system_reset)
      else $error("illegal flash write not reset");
   a_flash_read: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && (code_move_read || branch_fetch)
         && access_addr > `RSL_USER_CODE_LIMIT) |=> system_reset)
      else $error("illegal flash read not reset");
   a_security: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && security_violation) |=> system_reset)
      else $error("security violation not reset");
   a_flash_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && flash_error && !comp_fire && !watchdog_expired)
         |=> reset_source_register[`RSL_BIT_FLASH_ERROR])
      else $error("flash error flag missing");
   a_soft_flag: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && cause == RSL_CAUSE_SOFT)
         |=> reset_source_register[`RSL_BIT_SOFTWARE])
      else $error("software flag missing");
   a_hold_length: assert property (@(posedge core_clk) disable iff (!rstn)
      s_cause_seen |=> s_hold_then_release)
      else $error("reset hold length wrong");

   // the output follows the sequencer state, so the hold has no gap in it
   a_hold_asserted: assert property (@(posedge core_clk) disable iff (!rstn)
      s_hold_active |-> system_reset)
      else $error("reset dropped during hold");

   // late causes are dropped, not queued, so the first cause stays readable
   a_source_stable: assert property (@(posedge core_clk) disable iff (!rstn)
      s_hold_active |=> $stable(reset_source_register))
      else $error("source changed during hold");

   // a collision records only the winner
   a_one_source: assert property (@(posedge core_clk) disable iff (!rstn)
      $onehot0(reset_source_register))
      else $error("more than one source flag set");

   // bits with no cause behind them always read zero
   a_spare_bits_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      reset_source_register[2:0] == 3'h0 && !reset_source_register[7])
      else $error("unused source bit set");

   // redirect is a registered copy, one cycle behind the write strobe
   a_redirect_set: assert property (@(posedge core_clk) disable iff (!rstn)
      (data_move_write && program_store_write_enable) |=> flash_write_redirect)
      else $error("data-move write not steered to flash");

   // without store enable the write stays in data memory
   a_redirect_clear: assert property (@(posedge core_clk) disable iff (!rstn)
      !(data_move_write && program_store_write_enable) |=> !flash_write_redirect)
      else $error("data-move write steered without store enable");

   // the watchdog beats flash and software causes when they meet
   a_wdog_wins: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && watchdog_expired && !comp_fire
         && (flash_error || software_reset_write))
         |=> !reset_source_register[`RSL_BIT_FLASH_ERROR]
         && !reset_source_register[`RSL_BIT_SOFTWARE])
      else $error("watchdog lost a collision");

   // a flash error beats a software request arriving in the same cycle
   a_soft_loses: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg.state == RSL_RUN && flash_error && software_reset_write && !comp_fire
         && !watchdog_expired) |=> !reset_source_register[`RSL_BIT_SOFTWARE])
      else $error("software flag set beside flash error");

   // internal reset is only ever high while the sequencer holds
   a_run_released: assert property (@(posedge core_clk) disable iff (!rstn)
      state_reg.state == RSL_RUN |-> !system_reset)
      else $error("reset high outside hold");
endmodule : rsl_reset_source

// ---- shared/rsl_defines.svh ----
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH

// reset source register bit positions
`define RSL_BIT_COMPARATOR 5
`define RSL_BIT_WATCHDOG 3
`define RSL_BIT_SOFTWARE 4
`define RSL_BIT_FLASH_ERROR 6
`define RSL_SRC_WIDTH 8
// last legal user code address
`define RSL_USER_CODE_LIMIT 16'h3dff
// internal reset hold time in ns, and derived cycles at 200 MHz
`define RSL_CLK_PERIOD_NS 5
`define RSL_HOLD_NS 80
`define RSL_HOLD_CYCLES ((`RSL_HOLD_NS + `RSL_CLK_PERIOD_NS - 1) / `RSL_CLK_PERIOD_NS)
`define RSL_CNT_WIDTH 8

`endif

// ---- shared/rsl_pkg.sv ----
package rsl_pkg;
   // reset sequencer states, one-hot
   typedef enum logic [1:0] {
      RSL_RUN = 2'b01,
      RSL_HOLD = 2'b10
   } rsl_state_t;

   // which cause fired
   typedef enum logic [3:0] {
      RSL_CAUSE_NONE = 4'h0,
      RSL_CAUSE_COMP = 4'h1,
      RSL_CAUSE_WDOG = 4'h2,
      RSL_CAUSE_FLASH = 4'h4,
      RSL_CAUSE_SOFT = 4'h8
   } rsl_cause_t;
endpackage : rsl_pkg

// ---- rtl/rsl_flash_check.sv ----
`timescale 1ns/1ps
`include "rsl_defines.svh"

// combinational detector of illegal program memory accesses
module rsl_flash_check
   import rsl_pkg::*;
#(
   parameter logic [15:0] USER_CODE_LIMIT = `RSL_USER_CODE_LIMIT
) (
   input wire logic [15:0] access_addr,
   input wire logic data_move_write,
   input wire logic code_move_read,
   input wire logic branch_fetch,
   input wire logic program_store_write_enable,
   input wire logic security_violation,
   output logic flash_error
);
   function automatic logic above_user(input logic [15:0] a);
      above_user = a > USER_CODE_LIMIT;
   endfunction : above_user

   // a data-move write only lands in flash while store-write is enabled
   always_comb begin
      flash_error = (data_move_write && program_store_write_enable && above_user(access_addr))
         || (code_move_read && above_user(access_addr))
         || (branch_fetch && above_user(access_addr))
         || security_violation;
   end
endmodule : rsl_flash_check

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import rsl_pkg::*;
   localparam int HOLD = 2; // short hold keeps the run brief
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic comparator_out = 1'b1;
   logic comparator_reset_enable_flag = 1'b0;
   logic watchdog_expired = 1'b0;
   logic software_reset_write = 1'b0;
   logic [15:0] access_addr = 16'h0000;
   logic data_move_write = 1'b0;
   logic code_move_read = 1'b0;
   logic branch_fetch = 1'b0;
   logic program_store_write_enable = 1'b0;
   logic security_violation = 1'b0;
   logic flash_write_redirect, system_reset, ext_reset_pin_oe;
   logic [7:0] reset_source_register;
   logic [7:0] exp_q[$];
   logic rst_prev = 1'b0;
   logic redir_exp;
   logic [15:0] hi;
   int n_errors = 0;
   int total_checks = 0;
   int hold_cnt = 0;

   always #2.5 core_clk = ~core_clk;

   rsl_reset_source #(.HOLD_CYCLES(HOLD)) i_rsl_reset_source (.core_clk(core_clk),
      .rstn(rstn), .comparator_out(comparator_out),
      .comparator_reset_enable_flag(comparator_reset_enable_flag),
      .watchdog_expired(watchdog_expired), .software_reset_write(software_reset_write),
      .access_addr(access_addr), .data_move_write(data_move_write),
      .code_move_read(code_move_read), .branch_fetch(branch_fetch),
      .program_store_write_enable(program_store_write_enable),
      .security_violation(security_violation), .flash_write_redirect(flash_write_redirect),
      .system_reset(system_reset), .reset_source_register(reset_source_register),
      .ext_reset_pin_oe(ext_reset_pin_oe));

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // one-cycle cause: [0] comp low [1] wdog [2] dm write [3] cm read [4] branch [5] lock [6] sw
   task automatic fire(logic [6:0] c, logic [15:0] addr, logic [7:0] exp);
      int i;
      @(negedge core_clk);
      {software_reset_write, security_violation, branch_fetch} = c[6:4];
      {code_move_read, data_move_write, watchdog_expired} = c[3:1];
      comparator_out = ~c[0];
      access_addr = addr;
      if (exp != 8'h00) exp_q.push_back(exp);
      @(negedge core_clk);
      {software_reset_write, security_violation, branch_fetch} = 3'h0;
      {code_move_read, data_move_write, watchdog_expired} = 3'h0;
      comparator_out = 1'b1;
      // bounded wait for the hold to end, a hang ends the run
      for (i = 0; i < 40 && system_reset !== 1'b0; i++) @(negedge core_clk);
      if (i == 40) begin
         n_errors++;
         finish_test();
      end
      repeat (4) @(negedge core_clk);
   endtask : fire

   // monitor: pops the oldest note on each reset rise and measures the hold
   always @(posedge core_clk) begin
      redir_exp = data_move_write && program_store_write_enable;
      #1;
      if (rstn) begin
         check("ext_reset_pin_oe", 16'(ext_reset_pin_oe), 16'h0);
         check("flash_write_redirect", 16'(flash_write_redirect), 16'(redir_exp));
         if (system_reset && !rst_prev) begin
            hold_cnt = 0;
            if (exp_q.size() == 0) check("unexpected_reset", 16'h1, 16'h0);
            else check("source", 16'(reset_source_register), 16'(exp_q.pop_front()));
         end
         if (system_reset) hold_cnt++;
         if (!system_reset && rst_prev) check("hold", 16'(hold_cnt), 16'(HOLD));
         rst_prev = system_reset;
      end
   end

   initial begin
      void'($urandom(32'h9a18f9b0));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      check("source_after_reset", 16'(reset_source_register), 16'h0);
      hi = 16'h3e00 + 16'($urandom_range(0, 16'hc1ff));
      fire(7'h01, 16'h0000, 8'h00);
      // comparator output has been high and settled for cycles before enabling
      comparator_reset_enable_flag = 1'b1;
      fire(7'h01, 16'h0000, 8'h20);
      fire(7'h7f, hi, 8'h20);
      comparator_reset_enable_flag = 1'b0;
      fire(7'h02, 16'h0000, 8'h08);
      fire(7'h40, 16'h0000, 8'h10);
      fire(7'h04, hi, 8'h00);
      program_store_write_enable = 1'b1;
      fire(7'h04, 16'($urandom_range(0, 16'h3dff)), 8'h00);
      fire(7'h04, 16'h3dff, 8'h00);
      fire(7'h04, hi, 8'h40);
      fire(7'h08, 16'h3e00, 8'h40);
      fire(7'h08, 16'h3dff, 8'h00);
      fire(7'h10, 16'hffff, 8'h40);
      fire(7'h10, 16'h3dff, 8'h00);
      fire(7'h20, 16'($urandom_range(0, 16'h3dff)), 8'h40);
      fire(7'h06, hi, 8'h08);
      fire(7'h44, hi, 8'h40);
      program_store_write_enable = 1'b0;
      // a pin reset in mid-run is a cause of its own, so the recorded flag clears
      rstn = 1'b0;
      @(negedge core_clk);
      check("source_after_rstn", 16'(reset_source_register), 16'h0);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      check("pending_notes", 16'(exp_q.size()), 16'h0);
      finish_test();
   end
endmodule : testbench
